/* net_cfg_pkg.sv */
package net_cfg_pkg;

    // Feature word bit positions.
    localparam int unsigned TX_CSUM_BIT = 0;
    localparam int unsigned RX_CSUM_BIT = 1;
    localparam int unsigned MTU_FEAT_BIT = 3;
    localparam int unsigned ADDR_FEAT_BIT = 5;
    localparam int unsigned RX_SEG_TCP4_BIT = 7;
    localparam int unsigned RX_SEG_TCP6_BIT = 8;
    localparam int unsigned RX_CONGESTION_BIT = 9;
    localparam int unsigned RX_UDP_OFFLOAD_BIT = 10;
    localparam int unsigned TX_SEG_TCP4_BIT = 11;
    localparam int unsigned TX_SEG_TCP6_BIT = 12;
    localparam int unsigned TX_CONGESTION_BIT = 13;
    localparam int unsigned TX_UDP_OFFLOAD_BIT = 14;
    localparam int unsigned MERGEABLE_RX_BIT = 15;
    localparam int unsigned STATUS_FEAT_BIT = 16;
    localparam int unsigned CONTROL_QUEUE_BIT = 17;
    localparam int unsigned RX_MODE_BIT = 18;
    localparam int unsigned VLAN_FILTER_BIT = 19;
    localparam int unsigned ANNOUNCE_BIT = 21;
    localparam int unsigned MULTI_QUEUE_BIT = 22;
    localparam int unsigned ADDR_SET_BIT = 23;
    localparam int unsigned COALESCE_EXT_BIT = 61;
    localparam int unsigned STANDBY_BIT = 62;

    // Link status field bits.
    localparam int unsigned LINK_UP_BIT = 0;
    localparam int unsigned ANNOUNCE_REQ_BIT = 1;

    // Packet header encodings.
    localparam logic [7:0] CSUM_NEEDED_FLAG = 8'h01;
    localparam logic [7:0] DATA_VALID_FLAG = 8'h02;
    localparam logic [7:0] COALESCE_INFO_FLAG = 8'h04;
    localparam logic [7:0] SEG_TYPE_NONE = 8'h00;
    localparam logic [7:0] SEG_TYPE_TCP4 = 8'h01;
    localparam logic [7:0] SEG_TYPE_UDP = 8'h03;
    localparam logic [7:0] SEG_TYPE_TCP6 = 8'h04;
    localparam logic [7:0] SEG_CONGESTION_FLAG = 8'h80;
    localparam logic [7:0] HDR_LEN_FULL = 8'h0C;
    localparam logic [7:0] HDR_LEN_SHORT = 8'h0A;
    localparam logic [15:0] LINK_HDR_LEN = 16'h000E;

    // Limits.
    localparam logic [15:0] PAIR_MIN = 16'h0001;
    localparam logic [16:0] PAIR_MAX = 17'h08000;
    localparam logic [15:0] MTU_MIN = 16'h0044;
    localparam logic [15:0] MTU_PREFERRED = 16'h0500;

    // APB register byte offsets.
    localparam logic [7:0] ADDR_LO_OFS = 8'h00;
    localparam logic [7:0] ADDR_HI_OFS = 8'h04;
    localparam logic [7:0] STATUS_OFS = 8'h08;
    localparam logic [7:0] PAIRS_OFS = 8'h0C;
    localparam logic [7:0] MTU_OFS = 8'h10;
    localparam logic [7:0] OFFER_LO_OFS = 8'h14;
    localparam logic [7:0] OFFER_HI_OFS = 8'h18;
    localparam logic [7:0] ACCEPT_LO_OFS = 8'h1C;
    localparam logic [7:0] ACCEPT_HI_OFS = 8'h20;
    localparam logic [7:0] CONTROL_OFS = 8'h24;
    localparam logic [7:0] ACTIVE_OFS = 8'h28;
    localparam logic [7:0] HDR_OFS = 8'h2C;
    localparam logic [7:0] RX_LEN_OFS = 8'h30;

    // Control register bits.
    localparam int unsigned CTL_LEGACY = 0;
    localparam int unsigned CTL_BIG_ENDIAN = 1;
    localparam int unsigned CTL_ACCEPT_GO = 2;

    localparam logic [63:0] FEAT_RESET = 64'h0;

endpackage : net_cfg_pkg

/* net_feature_config_space.sv */
// Added by the designer: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none

// What this block does
// - Offload and control-queue features are dropped unless their base feature is accepted.
// - Receive congestion feature needs receive TCPv4 or TCPv6 segmentation.
// - Transmit congestion and coalesce extension need transmit TCP segmentation.
// - Address always readable; status field reads zero unless status is offered.
// - Status field defines only link-up and announce-request bits, read-only.
// - Offered pair limit is clamped to 1 through 0x8000.
// - Offered MTU is held between 1280 and 65535.
// - Offered MTU below 1280 is always raised to 1280.
// - MTU is latched once and never changes afterwards.
// - Received unsegmented frames over MTU plus link header are flagged for drop.
// - Accepted standby feature is shown on the standby output.
// - Only one pair active until a pair count is commanded with multiqueue.
// - Header flag and segment type bytes decoded with their encodings.
// - Legacy mode with big-endian guest swaps status, pairs and header fields.
// - Legacy header is two bytes shorter without mergeable receive buffers.
// - In legacy mode the driver may write the station address.
// - Status, control queue and multiqueue sit at feature bits 16, 17, 22.
module net_feature_config_space #(
    parameter logic [15:0] MTU_DEFAULT = 16'h05DC,
    parameter logic [15:0] PAIR_DEFAULT = 16'h0004
) (
    input wire logic sys_clk_i,
    input wire logic rst_i,
    input wire logic clk_en_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [7:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic [3:0] pstrb_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    input wire logic [47:0] station_addr_i,
    input wire logic link_up_i,
    input wire logic announce_req_i,
    input wire logic [15:0] mtu_cfg_i,
    input wire logic [15:0] pair_cfg_i,
    input wire logic [15:0] rx_len_i,
    input wire logic [7:0] rx_seg_type_i,
    output logic [47:0] station_address_o,
    output logic [15:0] active_pairs_o,
    output logic mtu_negotiated_o,
    output logic rx_drop_o,
    output logic standby_o,
    output logic [7:0] hdr_len_o
);
    import net_cfg_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    logic [63:0] offer_reg;
    logic [63:0] request_reg;
    logic [63:0] accept_reg;
    logic [2:0] control_reg;
    logic [47:0] station_address_reg;
    logic [15:0] mtu_reg;
    logic mtu_set_reg;
    logic [15:0] pair_limit_reg;
    logic [15:0] active_pairs_reg;
    logic [15:0] hdr_word_reg;
    logic [31:0] prdata_reg;
    logic pslverr_reg;
    logic rx_drop_reg;

    wire apb_setup = psel_i && !penable_i;
    wire apb_access = psel_i && penable_i;
    wire wr_en = apb_access && pwrite_i && clk_en_i;
    wire rd_en = apb_access && !pwrite_i && clk_en_i;
    wire legacy = control_reg[CTL_LEGACY];
    wire swap = legacy && control_reg[CTL_BIG_ENDIAN];

    ////////////////////////////////////////////////////////////////////////
    // Feature filtering is combinational so any accepted word is consistent.
    logic [63:0] req_masked;
    logic [63:0] acc_next;
    always_comb begin
        req_masked = request_reg & offer_reg;
        acc_next = req_masked;
        if (!req_masked[RX_CSUM_BIT]) begin
            acc_next[RX_SEG_TCP4_BIT] = 1'b0;
            acc_next[RX_SEG_TCP6_BIT] = 1'b0;
            acc_next[RX_UDP_OFFLOAD_BIT] = 1'b0;
        end
        if (!req_masked[TX_CSUM_BIT]) begin
            acc_next[TX_SEG_TCP4_BIT] = 1'b0;
            acc_next[TX_SEG_TCP6_BIT] = 1'b0;
            acc_next[TX_UDP_OFFLOAD_BIT] = 1'b0;
        end
        if (!req_masked[CONTROL_QUEUE_BIT]) begin
            acc_next[RX_MODE_BIT] = 1'b0;
            acc_next[VLAN_FILTER_BIT] = 1'b0;
            acc_next[ANNOUNCE_BIT] = 1'b0;
            acc_next[MULTI_QUEUE_BIT] = 1'b0;
            acc_next[ADDR_SET_BIT] = 1'b0;
        end
        if (!(acc_next[RX_SEG_TCP4_BIT] || acc_next[RX_SEG_TCP6_BIT])) begin
            acc_next[RX_CONGESTION_BIT] = 1'b0;
        end
        if (!(acc_next[TX_SEG_TCP4_BIT] || acc_next[TX_SEG_TCP6_BIT])) begin
            acc_next[TX_CONGESTION_BIT] = 1'b0;
            acc_next[COALESCE_EXT_BIT] = 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // pair limit clamp
    wire [15:0] pair_clamped = (pair_cfg_i < PAIR_MIN) ? PAIR_MIN :
        (17'(pair_cfg_i) > PAIR_MAX) ? PAIR_MAX[15:0] : pair_cfg_i;
    wire [15:0] mtu_clamped = (mtu_cfg_i < MTU_PREFERRED) ? MTU_PREFERRED :
        mtu_cfg_i;

    function automatic logic [15:0] order16(input logic [15:0] v,
                                            input logic sw);
        order16 = sw ? {v[7:0], v[15:8]} : v;
    endfunction : order16

    wire [15:0] status_val = offer_reg[STATUS_FEAT_BIT] ?
        {14'h0000, announce_req_i, link_up_i} : 16'h0000;
    wire [15:0] pairs_val = offer_reg[MULTI_QUEUE_BIT] ? pair_limit_reg :
        16'h0000;
    wire [15:0] mtu_val = offer_reg[MTU_FEAT_BIT] ? mtu_reg : 16'h0000;

    wire [7:0] hdr_len = (legacy && !accept_reg[MERGEABLE_RX_BIT]) ?
        HDR_LEN_SHORT : HDR_LEN_FULL;

    wire [7:0] seg_base = hdr_word_reg[15:8] & ~SEG_CONGESTION_FLAG;
    wire seg_known = (seg_base == SEG_TYPE_NONE) ||
        (seg_base == SEG_TYPE_TCP4) || (seg_base == SEG_TYPE_UDP) ||
        (seg_base == SEG_TYPE_TCP6);
    wire [7:0] flags_known = hdr_word_reg[7:0] &
        (CSUM_NEEDED_FLAG | DATA_VALID_FLAG | COALESCE_INFO_FLAG);

    logic [31:0] rd_mux;
    always_comb begin
        unique case (paddr_i)
            ADDR_LO_OFS: rd_mux = station_address_reg[31:0];
            ADDR_HI_OFS: rd_mux = {16'h0000, station_address_reg[47:32]};
            STATUS_OFS: rd_mux = {16'h0000, order16(status_val, swap)};
            PAIRS_OFS: rd_mux = {16'h0000, order16(pairs_val, swap)};
            MTU_OFS: rd_mux = {16'h0000, mtu_val};
            OFFER_LO_OFS: rd_mux = offer_reg[31:0];
            OFFER_HI_OFS: rd_mux = offer_reg[63:32];
            ACCEPT_LO_OFS: rd_mux = accept_reg[31:0];
            ACCEPT_HI_OFS: rd_mux = accept_reg[63:32];
            CONTROL_OFS: rd_mux = {29'h0, control_reg};
            ACTIVE_OFS: rd_mux = {16'h0000, active_pairs_reg};
            HDR_OFS: rd_mux = {hdr_len, 6'h00, seg_known,
                hdr_word_reg[15] & seg_known, flags_known, seg_base};
            RX_LEN_OFS: rd_mux = {15'h0000, rx_drop_reg, rx_len_i};
            default: rd_mux = 32'h0000_0000;
        endcase
    end

    wire addr_ok = (paddr_i[1:0] == 2'b00) && (paddr_i <= RX_LEN_OFS);

    ////////////////////////////////////////////////////////////////////////
    // The slave answers in the first access cycle, so no wait states.
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            prdata_reg <= 32'h0000_0000;
            pslverr_reg <= 1'b0;
        end else if (clk_en_i && apb_setup) begin
            prdata_reg <= pwrite_i ? 32'h0000_0000 : rd_mux;
            pslverr_reg <= !addr_ok;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // fields written only in legacy mode
    wire addr_lo_wr = wr_en && legacy && (paddr_i == ADDR_LO_OFS);
    wire addr_hi_wr = wr_en && legacy && (paddr_i == ADDR_HI_OFS);
    wire accept_go = control_reg[CTL_ACCEPT_GO];

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            station_address_reg <= 48'h0000_0000_0000;
        end else if (clk_en_i) begin
            if (addr_lo_wr) begin
                station_address_reg[31:0] <= pwdata_i;
            end else if (addr_hi_wr) begin
                station_address_reg[47:32] <= pwdata_i[15:0];
            end else if (!legacy && !accept_go) begin
                station_address_reg <= station_addr_i;
            end
        end
    end

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            offer_reg <= FEAT_RESET;
            request_reg <= FEAT_RESET;
            control_reg <= 3'b000;
            hdr_word_reg <= 16'h0000;
        end else if (wr_en) begin
            unique case (paddr_i)
                OFFER_LO_OFS: offer_reg[31:0] <= pwdata_i;
                OFFER_HI_OFS: offer_reg[63:32] <= pwdata_i;
                ACCEPT_LO_OFS: request_reg[31:0] <= pwdata_i;
                ACCEPT_HI_OFS: request_reg[63:32] <= pwdata_i;
                CONTROL_OFS: control_reg <= pwdata_i[2:0];
                HDR_OFS: hdr_word_reg <= order16(pwdata_i[15:0], swap);
                default: hdr_word_reg <= hdr_word_reg;
            endcase
        end
    end

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            accept_reg <= FEAT_RESET;
        end else if (clk_en_i) begin
            accept_reg <= acc_next;
        end
    end

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            mtu_reg <= MTU_MIN;
            mtu_set_reg <= 1'b0;
            pair_limit_reg <= PAIR_MIN;
        end else if (clk_en_i && !mtu_set_reg) begin
            mtu_reg <= mtu_clamped;
            mtu_set_reg <= 1'b1;
            pair_limit_reg <= pair_clamped;
        end
    end

    wire pair_cmd = wr_en && (paddr_i == ACTIVE_OFS) &&
        accept_reg[MULTI_QUEUE_BIT];
    wire [15:0] pair_req = pwdata_i[15:0];
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            active_pairs_reg <= PAIR_MIN;
        end else if (clk_en_i) begin
            if (!accept_reg[MULTI_QUEUE_BIT]) begin
                active_pairs_reg <= PAIR_MIN;
            end else if (pair_cmd && pair_req >= PAIR_MIN &&
                         pair_req <= pair_limit_reg) begin
                active_pairs_reg <= pair_req;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // oversize receive drop
    wire [16:0] rx_limit = 17'(mtu_reg) + 17'(LINK_HDR_LEN);
    wire rx_unseg = ((rx_seg_type_i & ~SEG_CONGESTION_FLAG) == SEG_TYPE_NONE);
    wire rx_over = accept_reg[MTU_FEAT_BIT] && rx_unseg &&
        (17'(rx_len_i) > rx_limit);
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            rx_drop_reg <= 1'b0;
        end else if (clk_en_i) begin
            rx_drop_reg <= rx_over;
        end
    end

    logic standby_reg;
    logic [7:0] hdr_len_reg;
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            standby_reg <= 1'b0;
            hdr_len_reg <= HDR_LEN_FULL;
        end else if (clk_en_i) begin
            standby_reg <= accept_reg[STANDBY_BIT];
            hdr_len_reg <= hdr_len;
        end
    end

    assign prdata_o = prdata_reg;
    assign pready_o = 1'b1;
    assign pslverr_o = pslverr_reg;
    assign station_address_o = station_address_reg;
    assign active_pairs_o = active_pairs_reg;
    assign mtu_negotiated_o = accept_reg[MTU_FEAT_BIT];
    assign rx_drop_o = rx_drop_reg;
    assign standby_o = standby_reg;
    assign hdr_len_o = hdr_len_reg;

endmodule : net_feature_config_space

`default_nettype wire

/* net_cfg_checker.sv */
`timescale 1ns/1ps
`default_nettype none
module net_cfg_checker
    import net_cfg_pkg::*;
(
    input wire logic sys_clk_i,
    input wire logic rst_i,
    input wire logic clk_en_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [7:0] paddr_i,
    input wire logic [31:0] prdata_o,
    input wire logic pslverr_o,
    input wire logic [15:0] active_pairs_o,
    input wire logic mtu_negotiated_o,
    input wire logic rx_drop_o,
    input wire logic [7:0] rx_seg_type_i,
    input wire logic [7:0] hdr_len_o
);
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (rst_i);
    wire logic wr_acc = clk_en_i && psel_i && penable_i && pwrite_i;
    wire logic setup_c = clk_en_i && psel_i && !penable_i;
    wire logic bad_adr = (paddr_i > 8'h30) || (paddr_i[1:0] != 2'b00);
    // Accept set may lag a write by up to two edges.
    wire logic cfg_wr = wr_acc && paddr_i >= OFFER_LO_OFS
        && paddr_i <= CONTROL_OFS;
    AST_HDR_LEN: assert property (
        hdr_len_o == HDR_LEN_FULL || hdr_len_o == HDR_LEN_SHORT)
        else $error("header length is neither 12 nor 10");
    AST_PAIRS_RANGE: assert property (
        active_pairs_o >= 16'h0001 && active_pairs_o <= 16'h8000)
        else $error("active pair count out of range");
    AST_PAIRS_CMD_ONLY: assert property (
        !$stable(active_pairs_o) |-> $past(wr_acc && paddr_i == ACTIVE_OFS))
        else $error("pair count moved without a command");
    AST_DROP_SEG: assert property (
        rx_drop_o && $past(clk_en_i) |-> $past(rx_seg_type_i[6:0]) == 7'h00)
        else $error("segmented frame flagged for drop");
    AST_DROP_NEEDS_MTU: assert property (
        rx_drop_o |-> mtu_negotiated_o || $past(mtu_negotiated_o))
        else $error("drop without negotiated MTU");
    AST_ERR_UNMAPPED: assert property (
        setup_c && bad_adr |=> pslverr_o)
        else $error("unmapped access not refused");
    AST_ERR_MAPPED: assert property (
        setup_c && !bad_adr |=> !pslverr_o)
        else $error("mapped access refused");
    AST_UNMAPPED_ZERO: assert property (
        setup_c && !pwrite_i && bad_adr |=> prdata_o == 32'h0)
        else $error("unmapped read not zero");
    AST_MTU_NEG_CAUSE: assert property (
        $changed(mtu_negotiated_o) |-> $past(cfg_wr) || $past(cfg_wr, 2))
        else $error("MTU negotiation moved on its own");
endmodule : net_cfg_checker
bind net_feature_config_space net_cfg_checker i_net_cfg_checker (
    .sys_clk_i, .rst_i, .clk_en_i, .psel_i, .penable_i, .pwrite_i,
    .paddr_i, .prdata_o, .pslverr_o, .active_pairs_o, .mtu_negotiated_o,
    .rx_drop_o, .rx_seg_type_i, .hdr_len_o);
`default_nettype wire

/* guest_driver_model.sv */
`timescale 1ns/1ps
`default_nettype none
module guest_driver_model (
    input wire logic clk_i,
    input wire logic pready_i,
    output logic psel_o,
    output logic penable_o,
    output logic pwrite_o,
    output logic [7:0] paddr_o,
    output logic [31:0] pwdata_o
);
    int hangs = 0;
    initial begin
        psel_o = 1'b0;
        penable_o = 1'b0;
        pwrite_o = 1'b0;
        paddr_o = 8'h00;
        pwdata_o = 32'h0;
    end
    // The driver learns address and link state by reads.
    // The model moves no frames, so it sends no oversize ones.
    // Released write data is inverted so a stale value never looks valid.
    task automatic xfer(input logic w, input logic [7:0] a,
                        input logic [31:0] d);
        int n;
        @(posedge clk_i);
        psel_o <= 1'b1;
        pwrite_o <= w;
        paddr_o <= a;
        pwdata_o <= d;
        @(posedge clk_i);
        penable_o <= 1'b1;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (pready_i !== 1'b1 && n < 64);
        if (n >= 64) hangs++;
        psel_o <= 1'b0;
        penable_o <= 1'b0;
        pwdata_o <= ~d;
    endtask : xfer
endmodule : guest_driver_model
`default_nettype wire

/* net_feature_config_space_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module net_feature_config_space_tb_top;
    import net_cfg_pkg::*;
    logic sys_clk_i = 1'b0, rst_i = 1'b1, link_up = 1'b1, ann = 1'b1;
    logic clk_en = 1'b1;
    logic psel, penable, pwrite, pready, pslverr, mtu_neg, drop, standby;
    logic [7:0] paddr, hdr_len, rx_seg = 8'h00;
    logic [31:0] pwdata, prdata, seed = 32'hF71A6837, dep, base, fin;
    logic [47:0] station_addr = 48'h0, station_out;
    logic [15:0] mtu_cfg = 16'h0, pair_cfg = 16'h0, rx_len = 16'h0;
    logic [15:0] pairs, mtu_e, lv[5], pv[4], pe[4];
    logic [7:0] sv[5];
    logic ev[5];
    logic [32:0] exp_q[$];
    int miscompares = 0, n_checks = 0, p, i;
    always #12.5 sys_clk_i = ~sys_clk_i;
    net_feature_config_space i_net_feature_config_space (
        .sys_clk_i(sys_clk_i), .rst_i(rst_i), .clk_en_i(clk_en),
        .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
        .paddr_i(paddr), .pwdata_i(pwdata), .pstrb_i(4'hF),
        .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
        .station_addr_i(station_addr), .link_up_i(link_up),
        .announce_req_i(ann), .mtu_cfg_i(mtu_cfg), .pair_cfg_i(pair_cfg),
        .rx_len_i(rx_len), .rx_seg_type_i(rx_seg),
        .station_address_o(station_out), .active_pairs_o(pairs),
        .mtu_negotiated_o(mtu_neg), .rx_drop_o(drop),
        .standby_o(standby), .hdr_len_o(hdr_len));
    guest_driver_model i_guest_driver_model (
        .clk_i(sys_clk_i), .pready_i(pready), .psel_o(psel),
        .penable_o(penable), .pwrite_o(pwrite), .paddr_o(paddr),
        .pwdata_o(pwdata));
    task automatic check(input logic [47:0] seen, input logic [47:0] exp);
        n_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic rd(input logic [7:0] a, input logic [32:0] e);
        exp_q.push_back(e);
        i_guest_driver_model.xfer(1'b0, a, 32'h0);
        if (i_guest_driver_model.hangs > 0) end_of_test();
    endtask : rd
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        i_guest_driver_model.xfer(1'b1, a, d);
        if (i_guest_driver_model.hangs > 0) end_of_test();
    endtask : wr
    task automatic settle;
        repeat (3) @(negedge sys_clk_i);
    endtask : settle
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr
    task automatic end_of_test;
        miscompares += i_guest_driver_model.hangs;
        // A read whose answer never came is a mismatch too.
        if (exp_q.size() != 0) miscompares++;
        $display("Checks %0d, mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : end_of_test
    ////////////////////////////////////////////////////////////////////////
    // Read results are matched in order against the noted expectations.
    always @(posedge sys_clk_i) begin
        if (psel && penable && pready === 1'b1 && !pwrite) begin
            if (exp_q.size() > 0) check({15'h0, pslverr, prdata},
                                        {15'h0, exp_q.pop_front()});
        end
    end
    initial begin
        #(25ns * 40000);
        miscompares++;
        end_of_test();
    end
    ////////////////////////////////////////////////////////////////////////
    initial begin
        dep = (32'h1 << RX_SEG_TCP4_BIT) | (32'h1 << RX_SEG_TCP6_BIT)
            | (32'h1 << RX_CONGESTION_BIT) | (32'h1 << RX_UDP_OFFLOAD_BIT)
            | (32'h1 << TX_SEG_TCP4_BIT) | (32'h1 << TX_CONGESTION_BIT)
            | (32'h1 << TX_UDP_OFFLOAD_BIT) | (32'h1 << MULTI_QUEUE_BIT)
            | (32'h1 << VLAN_FILTER_BIT) | (32'h1 << RX_MODE_BIT)
            | (32'h1 << ANNOUNCE_BIT) | (32'h1 << ADDR_SET_BIT);
        base = (32'h1 << RX_CSUM_BIT) | (32'h1 << TX_CSUM_BIT)
            | (32'h1 << CONTROL_QUEUE_BIT);
        fin = dep | base | (32'h1 << MTU_FEAT_BIT) | (32'h1 << ADDR_FEAT_BIT)
            | (32'h1 << STATUS_FEAT_BIT);
        for (p = 0; p < 2; p++) begin
            @(posedge sys_clk_i);
            mtu_cfg <= p ? 16'h2328 : 16'h0030;
            pair_cfg <= p ? 16'h9000 : 16'h0000;
            station_addr <= {seed[15:0], seed};
            mtu_e = p ? 16'h2328 : 16'h0500;
            rst_i <= 1'b1;
            repeat (12) @(posedge sys_clk_i);
            rst_i <= 1'b0;
            settle;
            check(pairs, 48'h1);
            check(station_out, station_addr);
            rd(STATUS_OFS, 33'h0);
            rd(ADDR_LO_OFS, {1'b0, station_addr[31:0]});
            wr(OFFER_LO_OFS, 32'hFFFFFFFF);
            wr(OFFER_HI_OFS, 32'hFFFFFFFF);
            rd(MTU_OFS, {17'h0, mtu_e});
            rd(PAIRS_OFS, p ? 33'h8000 : 33'h1);
            wr(MTU_OFS, 32'h1234);
            rd(MTU_OFS, {17'h0, mtu_e});
            seed = lfsr(seed);
        end
        wr(ACCEPT_LO_OFS, dep);
        rd(ACCEPT_LO_OFS, 33'h0);
        wr(ACCEPT_LO_OFS, dep | base);
        rd(ACCEPT_LO_OFS, {1'b0, dep | base});
        wr(ACCEPT_LO_OFS, base | 32'h2200);
        rd(ACCEPT_LO_OFS, {1'b0, base});
        wr(ACCEPT_HI_OFS, 32'h60000000);
        rd(ACCEPT_HI_OFS, 33'h40000000);
        settle;
        check(standby, 48'h1);
        wr(ACCEPT_LO_OFS, fin);
        rd(ACCEPT_LO_OFS, {1'b0, fin});
        settle;
        check(mtu_neg, 48'h1);
        rd(STATUS_OFS, 33'h3);
        @(posedge sys_clk_i);
        link_up <= 1'b0;
        rd(STATUS_OFS, 33'h2);
        pv = '{16'h0003, 16'h0000, 16'h8001, 16'h8000};
        pe = '{16'h0003, 16'h0003, 16'h0003, 16'h8000};
        for (i = 0; i < 4; i++) begin
            wr(ACTIVE_OFS, {16'h0, pv[i]});
            settle;
            check(pairs, pe[i]);
        end
        // A low clock enable must swallow a pair command.
        @(posedge sys_clk_i);
        clk_en <= 1'b0;
        wr(ACTIVE_OFS, 32'h0000_0005);
        @(posedge sys_clk_i);
        clk_en <= 1'b1;
        settle;
        check(pairs, 48'h8000);
        lv = '{16'h2336, 16'h2337, 16'h2337, 16'h2337, 16'h2337 + seed[7:0]};
        sv = '{8'h00, 8'h00, 8'h01, 8'h80, 8'h03};
        ev = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b0};
        for (i = 0; i < 5; i++) begin
            @(posedge sys_clk_i);
            rx_len <= lv[i];
            rx_seg <= sv[i];
            settle;
            check(drop, ev[i]);
        end
        wr(CONTROL_OFS, 32'h3);
        rd(STATUS_OFS, 33'h0200);
        rd(PAIRS_OFS, 33'h0080);
        wr(HDR_OFS, 32'h0000_0F83);
        rd(HDR_OFS, {1'b0, HDR_LEN_SHORT, 8'h03, CSUM_NEEDED_FLAG |
            DATA_VALID_FLAG | COALESCE_INFO_FLAG, SEG_TYPE_UDP});
        wr(HDR_OFS, 32'h0000_0285);
        rd(HDR_OFS, {1'b0, HDR_LEN_SHORT, 8'h00, DATA_VALID_FLAG,
            8'h05});
        wr(ADDR_LO_OFS, 32'h11223344);
        settle;
        check(station_out[31:0], 48'h11223344);
        check(hdr_len, HDR_LEN_SHORT);
        wr(ACCEPT_LO_OFS, fin | (32'h1 << MERGEABLE_RX_BIT));
        settle;
        check(hdr_len, HDR_LEN_FULL);
        // With the go bit and no legacy, the address must stay put.
        wr(CONTROL_OFS, 32'h4);
        @(posedge sys_clk_i);
        station_addr <= {seed, seed[31:16]};
        wr(ADDR_LO_OFS, 32'h55667788);
        settle;
        check(station_out[31:0], 48'h11223344);
        rd(8'h34, {1'b1, 32'h0});
        rd(8'h02, {1'b1, 32'h0});
        settle;
        end_of_test();
    end
endmodule : net_feature_config_space_tb_top
`default_nettype wire
